// File: design/bist_cable_pkg.sv
package bist_cable_pkg;
   // Register addresses on the management port
   localparam logic [4:0]  ADDR_MAIN_CTRL   = 5'h16;
   localparam logic [4:0]  ADDR_ERRCNT_GAP  = 5'h1b;
   localparam logic [4:0]  ADDR_PKT_LEN     = 5'h1c;
   localparam logic [4:0]  ADDR_DIAG_CTRL   = 5'h1e;
   localparam logic [4:0]  ADDR_INT_STATUS  = 5'h14;
   localparam logic [4:0]  ADDR_INT_MASK    = 5'h15;

   // Field positions
   localparam int          MAIN_GEN_BIT     = 0;
   localparam int          MAIN_CHK_BIT     = 1;
   localparam int          MAIN_MODE_BIT    = 2;
   localparam int          ERRCNT_LSB       = 8;
   localparam int          ERRCNT_CLR_BIT   = 15;
   localparam int          DIAG_START_BIT   = 15;
   localparam int          DIAG_QUAL_LSB    = 8;
   localparam int          DIAG_DONE_BIT    = 1;
   localparam int          DIAG_FAIL_BIT    = 0;

   // Interrupt status and mask layout
   localparam int          INT_W            = 3;
   localparam int          INT_DONE_BIT     = 0;
   localparam int          INT_FAIL_BIT     = 1;
   localparam int          INT_SAT_BIT      = 2;

   // Reset values
   localparam logic [7:0]  GAP_RESET        = 8'h7d;
   localparam logic [10:0] PKT_LEN_RESET    = 11'h5dc;
   localparam logic [2:0]  MAIN_RESET       = 3'h0;
   localparam logic [INT_W-1:0] MASK_RESET  = 3'h0;

   // Link quality grades
   typedef enum logic [1:0] {
      QUAL_RSVD = 2'h0,
      QUAL_GOOD = 2'h1,
      QUAL_MID  = 2'h2,
      QUAL_POOR = 2'h3
   } link_qual_e;

   // Outcome of one cable measurement
   typedef struct packed {
      logic       done;
      logic       fail;
      link_qual_e qual;
   } diag_result_s;

   // Packet timer states
   typedef enum logic [2:0] {
      PT_IDLE = 3'b001,
      PT_PKT  = 3'b010,
      PT_GAP  = 3'b100
   } pkt_state_e;
endpackage : bist_cable_pkg

// File: design/selftest_pkt_timer.sv
`timescale 1ns/1ps
module selftest_pkt_timer
   import bist_cable_pkg::*;
#(
   parameter int LEN_W = 11,
   parameter int GAP_W = 8
) (
   input  wire logic             clk,
   input  wire logic             nrst,
   input  wire logic             run,
   input  wire logic             byteTick,
   input  wire logic [LEN_W-1:0] pktLen,
   input  wire logic [GAP_W-1:0] gapLen,
   output logic                  pktByte,
   output logic                  gapByte,
   output logic                  pktDone
);
   // Refuse widths the counter cannot serve
   initial begin
      if (LEN_W < GAP_W || LEN_W < 1 || GAP_W < 1) begin
         $error("selftest_pkt_timer: LEN_W must be at least GAP_W");
      end
   end

   pkt_state_e       state_q, state_d;
   logic [LEN_W-1:0] cnt_q, cnt_d;
   logic             pktDone_q, pktDone_d;

   // Byte position decodes
   wire logic [LEN_W-1:0] gapWide  = LEN_W'(gapLen);
   wire logic             lastPkt  = (cnt_q == pktLen - LEN_W'(1));
   wire logic             lastGap  = (cnt_q == gapWide - LEN_W'(1));
   wire logic             noGap    = (gapLen == '0);

   assign pktByte = byteTick && (state_q == PT_PKT);
   assign gapByte = byteTick && (state_q == PT_GAP);
   assign pktDone = pktDone_q;

   // Next state: packet bytes then gap bytes, repeated
   always_comb begin
      state_d   = state_q;
      cnt_d     = cnt_q;
      pktDone_d = 1'b0;
      unique case (state_q)
         PT_IDLE: begin
            cnt_d = '0;
            if (run && pktLen != '0) begin
               state_d = PT_PKT;
            end
         end
         PT_PKT: begin
            if (byteTick) begin
               if (lastPkt) begin
                  pktDone_d = 1'b1;
                  cnt_d     = '0;
                  state_d   = noGap ? PT_PKT : PT_GAP;
               end else begin
                  cnt_d = cnt_q + LEN_W'(1);
               end
            end
         end
         PT_GAP: begin
            if (byteTick) begin
               if (lastGap) begin
                  cnt_d   = '0;
                  state_d = PT_PKT;
               end else begin
                  cnt_d = cnt_q + LEN_W'(1);
               end
            end
         end
         default: begin
            state_d = PT_IDLE;
            cnt_d   = '0;
         end
      endcase
      if (!run) begin
         state_d = PT_IDLE;
         cnt_d   = '0;
      end
   end

   // State registers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_q   <= PT_IDLE;
         cnt_q     <= '0;
         pktDone_q <= 1'b0;
      end else begin
         state_q   <= state_d;
         cnt_q     <= cnt_d;
         pktDone_q <= pktDone_d;
      end
   end
endmodule : selftest_pkt_timer

// File: design/bist_cable_diag_regs.sv
`timescale 1ns/1ps
module bist_cable_diag_regs
   import bist_cable_pkg::*;
#(
   parameter int ERR_W = 8,
   parameter int GAP_W = 8,
   parameter int LEN_W = 11
) (
   input  wire logic             clk,
   input  wire logic             nrst,
   input  wire logic [4:0]       regAddr,
   input  wire logic [15:0]      regWdata,
   input  wire logic             regWrite,
   input  wire logic             regRead,
   output logic      [15:0]      regRdata,
   input  wire logic             errByte,
   input  wire logic             byteTick,
   output logic                  genRun,
   output logic                  chkRun,
   output logic                  pktByte,
   output logic                  gapByte,
   output logic                  pktDone,
   output logic                  diagRun,
   input  wire logic             measDone,
   input  wire logic             measFail,
   input  wire logic [1:0]       measQual,
   output logic                  irq
);
   // Refuse widths the register layout cannot hold
   initial begin
      if (ERR_W != 8 || GAP_W != 8 || LEN_W < 1 || LEN_W > 11) begin
         $error("bist_cable_diag_regs: field widths do not fit the register layout");
      end
   end

   // Address decodes
   wire logic selMain   = (regAddr == ADDR_MAIN_CTRL);
   wire logic selErr    = (regAddr == ADDR_ERRCNT_GAP);
   wire logic selLen    = (regAddr == ADDR_PKT_LEN);
   wire logic selDiag   = (regAddr == ADDR_DIAG_CTRL);
   wire logic selStat   = (regAddr == ADDR_INT_STATUS);
   wire logic selMask   = (regAddr == ADDR_INT_MASK);

   // Write strobes per register, status read strobe
   wire logic wrMain    = regWrite && selMain;
   wire logic wrErr     = regWrite && selErr;
   wire logic wrLen     = regWrite && selLen;
   wire logic wrDiag    = regWrite && selDiag;
   wire logic wrMask    = regWrite && selMask;
   wire logic rdStat    = regRead && selStat;

   // Control and configuration state
   logic [2:0]            main_q;
   logic [GAP_W-1:0]      gap_q;
   logic [LEN_W-1:0]      pktLen_q;
   logic [INT_W-1:0]      mask_q;
   logic [INT_W-1:0]      status_q, status_d;
   logic [15:0]           rdata_q, rdata_d;

   // Error counter state
   logic [ERR_W-1:0]      errCnt_q, errCnt_d;
   logic [ERR_W-1:0]      errSnap_q;
   logic                  errLock_q;

   // Diagnostic state
   logic                  start_q, start_d;
   diag_result_s          result_q, result_d;

   // Main control bits
   wire logic countWrap = main_q[MAIN_MODE_BIT];
   assign genRun  = main_q[MAIN_GEN_BIT];
   assign chkRun  = main_q[MAIN_CHK_BIT];

   // Freeze and clear requests
   wire logic freezeReq = wrMain && (regWdata[MAIN_GEN_BIT] || regWdata[MAIN_CHK_BIT]);
   wire logic unfreeze  = wrMain && !regWdata[MAIN_GEN_BIT] && !regWdata[MAIN_CHK_BIT];
   wire logic clearReq  = wrErr && regWdata[ERRCNT_CLR_BIT];

   // Counter saturation decode
   wire logic errFull   = (errCnt_q == {ERR_W{1'b1}});
   wire logic errHold   = errFull && !countWrap;
   wire logic errInc    = errByte && chkRun && !errHold;
   wire logic satEvent  = errByte && chkRun && errFull;

   // Running error counter
   always_comb begin
      errCnt_d = errCnt_q;
      if (clearReq) begin
         errCnt_d = '0;
      end else if (errInc) begin
         errCnt_d = errCnt_q + ERR_W'(1);
      end
   end

   // Value shown in the upper byte
   wire logic [ERR_W-1:0] errShown = errLock_q ? errSnap_q : errCnt_q;

   // Main control register
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         main_q <= MAIN_RESET;
      end else if (wrMain) begin
         main_q <= regWdata[2:0];
      end
   end

   // Gap and packet length fields
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         gap_q    <= GAP_RESET;
         pktLen_q <= PKT_LEN_RESET[LEN_W-1:0];
      end else begin
         if (wrErr) begin
            gap_q <= regWdata[GAP_W-1:0];
         end
         if (wrLen) begin
            pktLen_q <= regWdata[LEN_W-1:0];
         end
      end
   end

   // Error count, snapshot and lock
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         errCnt_q  <= '0;
         errSnap_q <= '0;
         errLock_q <= 1'b0;
      end else begin
         errCnt_q <= errCnt_d;
         if (freezeReq || clearReq) begin
            errSnap_q <= errCnt_q;
            errLock_q <= 1'b1;
         end else if (unfreeze) begin
            errLock_q <= 1'b0;
         end
      end
   end

   // Start bit launch and completion decodes
   wire logic startWr   = wrDiag && regWdata[DIAG_START_BIT];
   wire logic launch    = startWr && !start_q;
   wire logic doneEvent = start_q && measDone;

   // Diagnostic start and result
   always_comb begin
      start_d  = start_q;
      result_d = result_q;
      if (wrDiag) begin
         start_d = regWdata[DIAG_START_BIT];
      end
      if (launch) begin
         result_d.done = 1'b0;
         result_d.fail = 1'b0;
      end
      if (doneEvent && !launch) begin
         start_d       = 1'b0;
         result_d.done = 1'b1;
         result_d.fail = measFail;
         result_d.qual = link_qual_e'(measQual);
      end
   end

   assign diagRun = start_q;

   // Diagnostic registers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         start_q  <= 1'b0;
         result_q <= '{done: 1'b0, fail: 1'b0, qual: QUAL_RSVD};
      end else begin
         start_q  <= start_d;
         result_q <= result_d;
      end
   end

   // Interrupt events
   wire logic [INT_W-1:0] intEvent = {satEvent,
                                      doneEvent && !launch && measFail,
                                      doneEvent && !launch};

   // Sticky status, read clears, new event wins
   always_comb begin
      status_d = status_q;
      if (rdStat) begin
         status_d = '0;
      end
      status_d = status_d | intEvent;
   end

   // Interrupt status and mask
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         status_q <= '0;
         mask_q   <= MASK_RESET;
      end else begin
         status_q <= status_d;
         if (wrMask) begin
            mask_q <= regWdata[INT_W-1:0];
         end
      end
   end

   assign irq = |(status_q & mask_q);

   // Read views, reserved bits zero
   wire logic [15:0] viewMain = {13'h0000, main_q};
   wire logic [15:0] viewErr  = {errShown, gap_q};
   wire logic [15:0] viewLen  = {{(16 - LEN_W){1'b0}}, pktLen_q};
   wire logic [15:0] viewDiag = {start_q, 5'h00, result_q.qual, 6'h00,
                                 result_q.done, result_q.fail};
   wire logic [15:0] viewStat = {{(16 - INT_W){1'b0}}, status_q};
   wire logic [15:0] viewMask = {{(16 - INT_W){1'b0}}, mask_q};

   // Read data multiplexer, unmapped reads zero
   always_comb begin
      rdata_d = 16'h0000;
      if (regRead) begin
         if (selMain) begin
            rdata_d = viewMain;
         end else if (selErr) begin
            rdata_d = viewErr;
         end else if (selLen) begin
            rdata_d = viewLen;
         end else if (selDiag) begin
            rdata_d = viewDiag;
         end else if (selStat) begin
            rdata_d = viewStat;
         end else if (selMask) begin
            rdata_d = viewMask;
         end
      end
   end

   // Read data stands only the cycle after the strobe
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata_q <= 16'h0000;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign regRdata = rdata_q;

   // Packet and gap sequencing
   selftest_pkt_timer #(
      .LEN_W (LEN_W),
      .GAP_W (GAP_W)
   ) u_pkt_timer (
      .clk      (clk),
      .nrst     (nrst),
      .run      (genRun),
      .byteTick (byteTick),
      .pktLen   (pktLen_q),
      .gapLen   (gap_q),
      .pktByte  (pktByte),
      .gapByte  (gapByte),
      .pktDone  (pktDone)
   );
endmodule : bist_cable_diag_regs

// File: verification/bist_cable_diag_regs_monitor.sv
`timescale 1ns/1ps
module bist_cable_diag_regs_monitor
   import bist_cable_pkg::*;
#(
   parameter int ERR_W = 8,
   parameter int GAP_W = 8,
   parameter int LEN_W = 11
) (
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic [4:0]  regAddr,
   input wire logic [15:0] regWdata,
   input wire logic        regWrite,
   input wire logic        regRead,
   input wire logic [15:0] regRdata,
   input wire logic        errByte,
   input wire logic        byteTick,
   input wire logic        genRun,
   input wire logic        chkRun,
   input wire logic        pktByte,
   input wire logic        gapByte,
   input wire logic        pktDone,
   input wire logic        diagRun,
   input wire logic        measDone,
   input wire logic        measFail,
   input wire logic [1:0]  measQual,
   input wire logic        irq
);
   // Decoded writes
   wire diagWr = regWrite && (regAddr == ADDR_DIAG_CTRL);
   wire mainWr = regWrite && (regAddr == ADDR_MAIN_CTRL);

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   // Reserved bits, launch, stop, self-clear, result and timer relations
   rsv_length_a: assert property ($past(regRead) && $past(regAddr) == ADDR_PKT_LEN
      |-> regRdata[15:11] == 5'h00) else $error("length reserved bits set");
   rsv_diag_a: assert property ($past(regRead) && $past(regAddr) == ADDR_DIAG_CTRL
      |-> regRdata[14:10] == 5'h00 && regRdata[7:2] == 6'h00) else $error("diag reserved bits set");
   diag_launch_a: assert property (diagWr && regWdata[15] && !diagRun |=> diagRun)
      else $error("start did not launch");
   diag_stop_a: assert property (diagWr && !regWdata[15] |=> !diagRun)
      else $error("start zero did not stop");
   diag_cause_a: assert property ($rose(diagRun) |-> $past(diagWr) && $past(regWdata[15]))
      else $error("run without start write");
   start_clear_a: assert property (diagRun && measDone && !diagWr |=> !diagRun)
      else $error("start bit not cleared");
   done_read_a: assert property ((diagRun && measDone && !diagWr) ##2 (regRead && regAddr == ADDR_DIAG_CTRL)
      |=> regRdata[1] && regRdata[0] == $past(measFail, 3) && regRdata[9:8] == $past(measQual, 3))
      else $error("diag result wrong");
   run_ctrl_a: assert property (mainWr |=> genRun == $past(regWdata[0]) && chkRun == $past(regWdata[1]))
      else $error("run bits wrong");
   pkt_byte_a: assert property (pktByte |-> byteTick && !gapByte)
      else $error("packet byte without tick");
   pkt_done_a: assert property (pktDone |-> $past(pktByte))
      else $error("done without packet byte");
endmodule : bist_cable_diag_regs_monitor

bind bist_cable_diag_regs bist_cable_diag_regs_monitor #(.ERR_W(ERR_W), .GAP_W(GAP_W), .LEN_W(LEN_W)) u_mon (
   .clk(clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
   .regRead(regRead), .regRdata(regRdata), .errByte(errByte), .byteTick(byteTick),
   .genRun(genRun), .chkRun(chkRun), .pktByte(pktByte), .gapByte(gapByte), .pktDone(pktDone),
   .diagRun(diagRun), .measDone(measDone), .measFail(measFail), .measQual(measQual), .irq(irq));

// File: verification/testbench.sv
`timescale 1ns/1ps
module testbench
   import bist_cable_pkg::*;
   ;
   typedef struct packed {logic wr; logic [4:0] addr; logic [15:0] val;} row_s;
   logic        clk = 1'b0;
   logic        nrst, regWrite, regRead, errByte, byteTick, measDone, measFail;
   logic [4:0]  regAddr;
   logic [15:0] regWdata, regRdata, rdv;
   logic [1:0]  measQual, pq;
   logic        genRun, chkRun, pktByte, gapByte, pktDone, diagRun, irq;
   int          nMismatch, numChecks;
   // Reset values, reserved bits, unmapped index
   row_s rows [13] = '{'{1'b0, 5'h1b, 16'h007d}, '{1'b0, 5'h1c, 16'h05dc}, '{1'b0, 5'h1e, 16'h0000},
      '{1'b0, 5'h15, 16'h0000}, '{1'b1, 5'h1c, 16'hffff}, '{1'b0, 5'h1c, 16'h07ff},
      '{1'b1, 5'h1b, 16'h7f02}, '{1'b0, 5'h1b, 16'h0002}, '{1'b1, 5'h1e, 16'h7fff},
      '{1'b0, 5'h1e, 16'h0000}, '{1'b1, 5'h19, 16'hffff}, '{1'b0, 5'h19, 16'h0000},
      '{1'b1, 5'h1c, 16'h0003}};

   bist_cable_diag_regs u_dut (.clk(clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
      .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .errByte(errByte), .byteTick(byteTick),
      .genRun(genRun), .chkRun(chkRun), .pktByte(pktByte), .gapByte(gapByte), .pktDone(pktDone),
      .diagRun(diagRun), .measDone(measDone), .measFail(measFail), .measQual(measQual), .irq(irq));

   // Clock
   always #20 clk = ~clk;

   task chk(input logic [15:0] seen, input logic [15:0] exp);
      numChecks++;
      if (seen !== exp) begin
         nMismatch++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk);
      regWrite <= 1'b1;
      regAddr  <= a;
      regWdata <= d;
      @(posedge clk);
      regWrite <= 1'b0;
      #1;
   endtask : wr

   task rd(input logic [4:0] a);
      @(posedge clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRead <= 1'b0;
      #1;
      rdv = regRdata;
   endtask : rd

   task errs(input int n);
      repeat (n) begin
         @(posedge clk);
         errByte <= 1'b1;
      end
      @(posedge clk);
      errByte <= 1'b0;
   endtask : errs

   task meas(input logic f, input logic [1:0] q);
      @(posedge clk);
      measDone <= 1'b1;
      measFail <= f;
      measQual <= q;
      @(posedge clk);
      measDone <= 1'b0;
      #1;
   endtask : meas

   task end_sim;
      $display("checks %0d mismatches %0d", numChecks, nMismatch);
      if (nMismatch == 0 && numChecks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : end_sim

   // Watchdog
   initial begin
      repeat (6000) @(posedge clk);
      nMismatch++;
      end_sim();
   end

   // Main sequence
   initial begin
      {nrst, regWrite, regRead, errByte, byteTick, measDone, measFail} = 7'h00;
      regAddr = 5'h00;
      regWdata = 16'h0000;
      measQual = 2'h0;
      pq = 2'h0;
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      foreach (rows[i]) begin
         if (rows[i].wr) begin
            wr(rows[i].addr, rows[i].val);
         end else begin
            rd(rows[i].addr);
            chk(rdv, rows[i].val);
         end
      end
      // Error counter: freeze, live count, saturation, capture
      wr(ADDR_MAIN_CTRL, 16'h0002);
      errs(3);
      rd(ADDR_ERRCNT_GAP);
      chk(rdv, 16'h0002);
      wr(ADDR_MAIN_CTRL, 16'h0000);
      rd(ADDR_ERRCNT_GAP);
      chk(rdv, 16'h0302);
      wr(ADDR_MAIN_CTRL, 16'h0002);
      errs(260);
      wr(ADDR_MAIN_CTRL, 16'h0000);
      rd(ADDR_ERRCNT_GAP);
      chk(rdv, 16'hff02);
      rd(ADDR_INT_STATUS);
      chk(rdv, 16'h0004);
      wr(ADDR_ERRCNT_GAP, 16'h8002);
      rd(ADDR_ERRCNT_GAP);
      chk(rdv, 16'hff02);
      wr(ADDR_MAIN_CTRL, 16'h0000);
      rd(ADDR_ERRCNT_GAP);
      chk(rdv, 16'h0002);
      // Diagnostic with the GOOD, MID and POOR grades, interrupt and clear-on-read
      wr(ADDR_INT_MASK, 16'h0003);
      for (int q = 1; q < 4; q++) begin
         wr(ADDR_DIAG_CTRL, 16'h8000);
         chk({15'h0, diagRun}, 16'h0001);
         rd(ADDR_DIAG_CTRL);
         chk(rdv, {1'b1, 5'h00, pq, 8'h00});
         meas(q[0], q[1:0]);
         chk({14'h0, diagRun, irq}, 16'h0001);
         rd(ADDR_DIAG_CTRL);
         chk(rdv, {6'h00, q[1:0], 6'h00, 1'b1, q[0]});
         rd(ADDR_INT_STATUS);
         chk(rdv, {14'h0, q[0], 1'b1});
         chk({15'h0, irq}, 16'h0000);
         pq = q[1:0];
      end
      // Abort and stray completion while idle
      wr(ADDR_DIAG_CTRL, 16'h8000);
      wr(ADDR_DIAG_CTRL, 16'h0000);
      meas(1'b1, 2'h1);
      rd(ADDR_DIAG_CTRL);
      chk(rdv, 16'h0300);
      // Packet timer, length 3 and gap 2
      wr(ADDR_MAIN_CTRL, 16'h0001);
      @(posedge clk);
      byteTick <= 1'b1;
      for (int i = 0; i < 10; i++) begin
         #1;
         chk({13'h0, pktByte, gapByte, pktDone}, {13'h0, (i % 5) < 3, (i % 5) > 2, (i % 5) == 3});
         @(posedge clk);
      end
      byteTick <= 1'b0;
      wr(ADDR_MAIN_CTRL, 16'h0000);
      // Second reset after the generator is stopped
      @(posedge clk);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      #1;
      chk({10'h0, genRun, chkRun, diagRun, irq, pktDone, gapByte}, 16'h0000);
      rd(ADDR_ERRCNT_GAP);
      chk(rdv, 16'h007d);
      rd(ADDR_DIAG_CTRL);
      chk(rdv, 16'h0000);
      end_sim();
   end
endmodule : testbench
